// *** src/lpmc_pkg.sv ***
// Constants, register layout and state encoding of the low-power mode controller.
package lpmc_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0]  CTRL_OFFSET        = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET      = 8'h04;
  localparam logic [7:0]  WAKE_CFG_OFFSET    = 8'h08;

  // Field positions in power_control_reg.
  localparam int unsigned CTRL_REG_LP_BIT    = 0;
  localparam int unsigned CTRL_STBY_SEL_BIT  = 1;
  localparam int unsigned CTRL_WUF_CLR_BIT   = 2;
  localparam int unsigned CTRL_STANDBY_ENTERED_FLAG_CLR_BIT  = 3;
  localparam int unsigned CTRL_LOW_DRV_BIT   = 18;
  localparam int unsigned CTRL_SRAM1_SW_BIT  = 20;
  localparam int unsigned CTRL_SRAM2_SW_BIT  = 21;

  // Field positions in power_status_reg and the wakeup configuration register.
  localparam int unsigned STAT_WUF_BIT       = 0;
  localparam int unsigned STAT_STANDBY_ENTERED_FLAG_BIT      = 1;
  localparam int unsigned WCFG_PIN_EN_BIT    = 0;

  // Values after reset and the set of bits that software may store.
  localparam logic [31:0] CTRL_RESET         = 32'h0000_8000;
  localparam logic [31:0] CTRL_RW_MASK       = 32'h0034_c1f3;
  localparam logic [31:0] STATUS_RESET       = 32'h0000_0000;
  localparam logic        WCFG_PIN_EN_RESET  = 1'b0;

  // Fetch address handed to the core after the power-on sequence.
  localparam logic [31:0] BOOT_ADDR          = 32'h0000_0000;

  // Timing: figures in their own unit, cycle counts derived from the clock rate.
  localparam int unsigned CLK_MHZ            = 100;
  localparam int unsigned OSC_WAKE_NS        = 2000;
  localparam int unsigned REG_WAKE_NS        = 5000;
  localparam int unsigned POR_NS             = 10000;
  localparam int unsigned OSC_WAKE_CYC       = (OSC_WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned REG_WAKE_CYC       = (REG_WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned POR_CYC            = (POR_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W              = 16;

  // AXI response codes.
  localparam logic [1:0]  RESP_OKAY          = 2'b00;
  localparam logic [1:0]  RESP_SLVERR        = 2'b10;

  typedef enum logic [2:0] {
    LPMC_RUN       = 3'b000,
    LPMC_SLEEP     = 3'b001,
    LPMC_DEEP      = 3'b010,
    LPMC_DEEP_WAKE = 3'b011,
    LPMC_STANDBY   = 3'b100,
    LPMC_POR       = 3'b101
  } lpmc_state_t;

endpackage

// *** src/lpmc_sync.sv ***
// Two-flop synchroniser for pins and signals from other clock domains.
`timescale 1ns/1ps
`default_nettype none
module lpmc_sync #(
  parameter int unsigned     WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // Each bit gets its own pair; only the second stage is ever read outside.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        meta_reg[i] <= RESET_VAL[i];
        sync_o[i]   <= RESET_VAL[i];
      end else begin
        meta_reg[i] <= async_i[i];
        sync_o[i]   <= meta_reg[i];
      end
    end
  end

endmodule // lpmc_sync
`default_nettype wire

// *** src/lpmc_ctrl.sv ***
// Low-power mode controller: mode sequencing, power controls and AXI4-Lite registers.
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl #(
  parameter int unsigned OSC_WAKE_CYCLES = lpmc_pkg::OSC_WAKE_CYC,
  parameter int unsigned REG_WAKE_CYCLES = lpmc_pkg::REG_WAKE_CYC,
  parameter int unsigned POR_CYCLES      = lpmc_pkg::POR_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Processor core, same clock.
  input  wire logic        wait_for_interrupt_instr_i,
  input  wire logic        wait_for_event_instr_i,
  input  wire logic        isr_return_lowest_i,
  input  wire logic        core_deep_request_i,
  input  wire logic        sleep_after_isr_return_i,
  input  wire logic        event_on_pending_irq_i,
  input  wire logic        irq_pending_i,
  input  wire logic        wakeup_event_i,
  // External interrupt line controller, same clock.
  input  wire logic        ext_line_irq_i,
  input  wire logic        ext_line_event_i,
  input  wire logic        ext_line_pending_i,
  // Standby wakeup sources.
  input  wire logic        free_watchdog_reset_i,
  input  wire logic        rtc_alarm_i,
  input  wire logic        external_reset_pin_n_i,
  input  wire logic        wakeup_pin_i,
  // Power, clock and pad controls.
  output logic             core_clk_en_o,
  output logic             domain_clk_en_o,
  output logic             internal_8mhz_osc_en_o,
  output logic             high_speed_crystal_osc_en_o,
  output logic             pll_en_o,
  output logic             core_regulator_on_o,
  output logic             core_regulator_low_power_o,
  output logic             core_regulator_low_drive_o,
  output logic             sram_bank1_power_o,
  output logic             sram_bank2_power_o,
  output logic             sysclk_to_internal_8mhz_osc_o,
  output logic             deep_entry_skipped_o,
  output logic             por_reset_o,
  output logic [31:0]      boot_addr_o,
  output logic             io_hiz_o,
  output logic             wakeup_pin_keep_o
);

  typedef lpmc_pkg::lpmc_state_t state_t;

  state_t                        state_reg;
  state_t                        state_next;
  logic [lpmc_pkg::CNT_W-1:0]    cnt_reg;
  logic [lpmc_pkg::CNT_W-1:0]    cnt_next;
  logic [31:0]                   ctrl_reg;
  logic                          wuf_reg;
  logic                          standby_entered_flag_reg;
  logic                          pin_en_reg;
  logic                          by_event_reg;
  logic                          sev_reg;
  logic                          low_power_reg;
  logic                          low_drive_reg;
  logic                          sram1_off_reg;
  logic                          sram2_off_reg;
  logic                          wakeup_pin_prev_reg;
  logic [2:0]                    pins_sync;
  logic                          external_reset_pin_low;
  logic                          rtc_alarm;
  logic                          wakeup_pin_rise;
  logic                          entry;
  logic                          wake_sleep;
  logic                          wake_deep;
  logic                          wake_standby;
  logic                          aw_have_reg;
  logic                          w_have_reg;
  logic [7:0]                    aw_addr_reg;
  logic [31:0]                   w_data_reg;
  logic [3:0]                    w_strb_reg;
  logic                          wr_fire;
  logic                          wr_ctrl;
  logic [31:0]                   strb_mask;
  logic                          wuf_clr;
  logic                          standby_entered_flag_clr;
  logic [31:0]                   rd_data;
  logic                          rd_hit;

  // Reset pin idles high, so its synchroniser starts high to avoid a false wake.
  lpmc_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'b001)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({wakeup_pin_i, rtc_alarm_i, external_reset_pin_n_i}),
    .sync_o  (pins_sync)
  );

  assign external_reset_pin_low  = ~pins_sync[0];
  assign rtc_alarm = pins_sync[1];
  assign wakeup_pin_rise = pins_sync[2] & ~wakeup_pin_prev_reg & pin_en_reg;

  // Entry point: at the instruction, or at the last ISR return when sleep-on-exit is set.
  assign entry = sleep_after_isr_return_i ? isr_return_lowest_i
               : (wait_for_interrupt_instr_i | wait_for_event_instr_i);

  // Wait-for-interrupt sleep listens to every interrupt; the event path widens with send-on-pending.
  assign wake_sleep = by_event_reg ? (wakeup_event_i | (sev_reg & irq_pending_i))
                                   : irq_pending_i;
  // Deep-sleep listens only to the external lines.
  assign wake_deep = by_event_reg ? (ext_line_event_i | (sev_reg & ext_line_irq_i))
                                  : ext_line_irq_i;
  assign wake_standby = external_reset_pin_low | rtc_alarm | free_watchdog_reset_i | wakeup_pin_rise;

  // Mode sequencer.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      lpmc_pkg::LPMC_RUN: begin
        if (entry) begin
          if (!core_deep_request_i) begin
            state_next = lpmc_pkg::LPMC_SLEEP;
          end else if (ctrl_reg[lpmc_pkg::CTRL_STBY_SEL_BIT]) begin
            state_next = lpmc_pkg::LPMC_STANDBY;
          end else if (!ext_line_pending_i) begin
            state_next = lpmc_pkg::LPMC_DEEP;
          end
        end
      end
      lpmc_pkg::LPMC_SLEEP: begin
        if (wake_sleep) begin
          state_next = lpmc_pkg::LPMC_RUN;
        end
      end
      lpmc_pkg::LPMC_DEEP: begin
        if (wake_deep) begin
          state_next = lpmc_pkg::LPMC_DEEP_WAKE;
          // Low-power regulator needs its own recovery on top of the oscillator.
          cnt_next = low_power_reg
                   ? lpmc_pkg::CNT_W'(OSC_WAKE_CYCLES + REG_WAKE_CYCLES - 1)
                   : lpmc_pkg::CNT_W'(OSC_WAKE_CYCLES - 1);
        end
      end
      lpmc_pkg::LPMC_DEEP_WAKE: begin
        if (cnt_reg == '0) begin
          state_next = lpmc_pkg::LPMC_RUN;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      lpmc_pkg::LPMC_STANDBY: begin
        if (wake_standby) begin
          state_next = lpmc_pkg::LPMC_POR;
          cnt_next   = lpmc_pkg::CNT_W'(POR_CYCLES - 1);
        end
      end
      lpmc_pkg::LPMC_POR: begin
        if (cnt_reg == '0) begin
          state_next = lpmc_pkg::LPMC_RUN;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = lpmc_pkg::LPMC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= lpmc_pkg::LPMC_RUN;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Settings are frozen at the request edge so later writes cannot change a mode in progress.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      by_event_reg  <= 1'b0;
      sev_reg       <= 1'b0;
      low_power_reg <= 1'b0;
      low_drive_reg <= 1'b0;
      sram1_off_reg <= 1'b0;
      sram2_off_reg <= 1'b0;
    end else if (state_reg == lpmc_pkg::LPMC_RUN && entry) begin
      by_event_reg  <= wait_for_event_instr_i & ~sleep_after_isr_return_i;
      sev_reg       <= event_on_pending_irq_i;
      low_power_reg <= ctrl_reg[lpmc_pkg::CTRL_REG_LP_BIT];
      low_drive_reg <= ctrl_reg[lpmc_pkg::CTRL_LOW_DRV_BIT];
      sram1_off_reg <= ctrl_reg[lpmc_pkg::CTRL_SRAM1_SW_BIT];
      sram2_off_reg <= ctrl_reg[lpmc_pkg::CTRL_SRAM2_SW_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wakeup_pin_prev_reg <= 1'b0;
    end else begin
      wakeup_pin_prev_reg <= pins_sync[2];
    end
  end

  // Power and clock controls follow the next state, so they change with the state.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      core_clk_en_o               <= 1'b1;
      domain_clk_en_o             <= 1'b1;
      internal_8mhz_osc_en_o      <= 1'b1;
      high_speed_crystal_osc_en_o <= 1'b1;
      pll_en_o                    <= 1'b1;
      core_regulator_on_o         <= 1'b1;
      core_regulator_low_power_o  <= 1'b0;
      core_regulator_low_drive_o  <= 1'b0;
      sram_bank1_power_o          <= 1'b1;
      sram_bank2_power_o          <= 1'b1;
      por_reset_o                 <= 1'b0;
      io_hiz_o                    <= 1'b0;
    end else begin
      core_clk_en_o               <= (state_next == lpmc_pkg::LPMC_RUN);
      domain_clk_en_o             <= (state_next == lpmc_pkg::LPMC_RUN)
                                   | (state_next == lpmc_pkg::LPMC_SLEEP);
      internal_8mhz_osc_en_o      <= (state_next != lpmc_pkg::LPMC_DEEP)
                                   & (state_next != lpmc_pkg::LPMC_STANDBY);
      high_speed_crystal_osc_en_o <= (state_next == lpmc_pkg::LPMC_RUN)
                                   | (state_next == lpmc_pkg::LPMC_SLEEP);
      pll_en_o                    <= (state_next == lpmc_pkg::LPMC_RUN)
                                   | (state_next == lpmc_pkg::LPMC_SLEEP);
      core_regulator_on_o         <= (state_next != lpmc_pkg::LPMC_STANDBY);
      core_regulator_low_power_o  <= (state_next == lpmc_pkg::LPMC_DEEP)
                                   & low_power_reg;
      core_regulator_low_drive_o  <= (state_next == lpmc_pkg::LPMC_DEEP)
                                   & low_drive_reg;
      sram_bank1_power_o          <= (state_next == lpmc_pkg::LPMC_STANDBY) ? 1'b0
                                   : !((state_next == lpmc_pkg::LPMC_DEEP)
                                       & sram1_off_reg);
      sram_bank2_power_o          <= (state_next == lpmc_pkg::LPMC_STANDBY) ? 1'b0
                                   : !((state_next == lpmc_pkg::LPMC_DEEP)
                                       & sram2_off_reg);
      por_reset_o                 <= (state_next == lpmc_pkg::LPMC_POR);
      io_hiz_o                    <= (state_next == lpmc_pkg::LPMC_STANDBY);
    end
  end

  // One-cycle notices: oscillator handover on Deep-sleep exit, and a refused entry.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sysclk_to_internal_8mhz_osc_o    <= 1'b0;
      deep_entry_skipped_o <= 1'b0;
      boot_addr_o          <= lpmc_pkg::BOOT_ADDR;
      wakeup_pin_keep_o    <= 1'b0;
    end else begin
      sysclk_to_internal_8mhz_osc_o    <= (state_reg == lpmc_pkg::LPMC_DEEP_WAKE)
                            & (state_next == lpmc_pkg::LPMC_RUN);
      deep_entry_skipped_o <= (state_reg == lpmc_pkg::LPMC_RUN) & entry
                            & core_deep_request_i
                            & ~ctrl_reg[lpmc_pkg::CTRL_STBY_SEL_BIT]
                            & ext_line_pending_i;
      boot_addr_o          <= lpmc_pkg::BOOT_ADDR;
      wakeup_pin_keep_o    <= pin_en_reg;
    end
  end

  // AXI write channels: address and data are taken in either order, answered together.
  assign wr_fire  = aw_have_reg & w_have_reg & ~s_axi_bvalid_o;
  assign wr_ctrl  = wr_fire & (aw_addr_reg == lpmc_pkg::CTRL_OFFSET);
  assign wuf_clr  = wr_ctrl & w_strb_reg[0] & w_data_reg[lpmc_pkg::CTRL_WUF_CLR_BIT];
  assign standby_entered_flag_clr = wr_ctrl & w_strb_reg[0] & w_data_reg[lpmc_pkg::CTRL_STANDBY_ENTERED_FLAG_CLR_BIT];
  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign strb_mask[8*b +: 8] = {8{w_strb_reg[b]}};
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_have_reg     <= 1'b0;
      w_have_reg      <= 1'b0;
      aw_addr_reg     <= '0;
      w_data_reg      <= '0;
      w_strb_reg      <= '0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= lpmc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_reg     <= 1'b1;
        aw_addr_reg     <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_reg     <= 1'b1;
        w_data_reg     <= s_axi_wdata_i;
        w_strb_reg     <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_reg    <= 1'b0;
        w_have_reg     <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= (aw_addr_reg == lpmc_pkg::CTRL_OFFSET
                        || aw_addr_reg == lpmc_pkg::STATUS_OFFSET
                        || aw_addr_reg == lpmc_pkg::WAKE_CFG_OFFSET)
                        ? lpmc_pkg::RESP_OKAY : lpmc_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Control register is lost across Standby, so the power-on sequence reloads it.
  always_ff @(posedge clk_i) begin
    if (reset_i || state_reg == lpmc_pkg::LPMC_POR) begin
      ctrl_reg   <= lpmc_pkg::CTRL_RESET;
      pin_en_reg <= lpmc_pkg::WCFG_PIN_EN_RESET;
    end else if (wr_fire) begin
      if (aw_addr_reg == lpmc_pkg::CTRL_OFFSET) begin
        ctrl_reg <= (ctrl_reg & ~(strb_mask & lpmc_pkg::CTRL_RW_MASK))
                  | (w_data_reg & strb_mask & lpmc_pkg::CTRL_RW_MASK);
      end
      if (aw_addr_reg == lpmc_pkg::WAKE_CFG_OFFSET && w_strb_reg[0]) begin
        pin_en_reg <= w_data_reg[lpmc_pkg::WCFG_PIN_EN_BIT];
      end
    end
  end

  // Status flags survive Standby; a set in the same cycle as a clear wins.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wuf_reg  <= lpmc_pkg::STATUS_RESET[lpmc_pkg::STAT_WUF_BIT];
      standby_entered_flag_reg <= lpmc_pkg::STATUS_RESET[lpmc_pkg::STAT_STANDBY_ENTERED_FLAG_BIT];
    end else begin
      if (rtc_alarm || wakeup_pin_rise) begin
        wuf_reg <= 1'b1;
      end else if (wuf_clr) begin
        wuf_reg <= 1'b0;
      end
      if (state_reg == lpmc_pkg::LPMC_RUN && state_next == lpmc_pkg::LPMC_STANDBY) begin
        standby_entered_flag_reg <= 1'b1;
      end else if (standby_entered_flag_clr) begin
        standby_entered_flag_reg <= 1'b0;
      end
    end
  end

  // Read decode; the two clear bits are never stored, so they read as zero.
  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr_i)
      lpmc_pkg::CTRL_OFFSET:     rd_data = ctrl_reg;
      lpmc_pkg::STATUS_OFFSET: begin
        rd_data[lpmc_pkg::STAT_WUF_BIT]  = wuf_reg;
        rd_data[lpmc_pkg::STAT_STANDBY_ENTERED_FLAG_BIT] = standby_entered_flag_reg;
      end
      lpmc_pkg::WAKE_CFG_OFFSET: rd_data[lpmc_pkg::WCFG_PIN_EN_BIT] = pin_en_reg;
      default:                   rd_hit = 1'b0;
    endcase
  end

  // Read channel: one read in flight, answered the cycle after the address is taken.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= lpmc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_data;
        s_axi_rresp_o   <= rd_hit ? lpmc_pkg::RESP_OKAY : lpmc_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

endmodule // lpmc_ctrl
`default_nettype wire

// *** bench/lpmc_core_model.sv ***
// Core model that turns a bench command into one-cycle sleep instruction or ISR-return pulses.
`timescale 1ns/1ps
`default_nettype none
module lpmc_core_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] cmd_i,
  output logic            wfi_o,
  output logic            wfe_o,
  output logic            isr_o
);
  // Each output follows cmd_i one edge later, so a pulse lasts as long as the command is held.
  always_ff @(posedge clk_i) begin
    wfi_o <= cmd_i == 2'h1;
    wfe_o <= cmd_i == 2'h2;
    isr_o <= cmd_i == 2'h3;
  end
endmodule // lpmc_core_model
`default_nettype wire

// *** bench/lpmc_ctrl_asserts.sv ***
// Checker on the mode controller ports.
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl_asserts (
  input wire logic clk_i, reset_i, wait_for_interrupt_instr_i, core_deep_request_i,
  input wire logic irq_pending_i, wakeup_event_i, ext_line_irq_i, ext_line_event_i,
  input wire logic ext_line_pending_i, core_clk_en_o, domain_clk_en_o, pll_en_o,
  input wire logic internal_8mhz_osc_en_o, core_regulator_on_o, sleep_after_isr_return_i,
  input wire logic sram_bank1_power_o, sysclk_to_internal_8mhz_osc_o, deep_entry_skipped_o, io_hiz_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Modes are told apart by their clock and regulator pattern, since the state is internal.
  wire slp = !core_clk_en_o && domain_clk_en_o;
  wire dp = !domain_clk_en_o && core_regulator_on_o && !internal_8mhz_osc_en_o;
  a_sleep_entry: assert property (core_clk_en_o && wait_for_interrupt_instr_i &&
    !core_deep_request_i && !sleep_after_isr_return_i |=> slp) else $error("no sleep");
  a_sleep_clocks: assert property (slp |-> pll_en_o && core_regulator_on_o)
    else $error("sleep clocks");
  a_sleep_wake: assert property (slp && irq_pending_i && wakeup_event_i |=> core_clk_en_o)
    else $error("sleep wake");
  a_deep_hold: assert property (dp && !ext_line_irq_i && !ext_line_event_i |=> dp)
    else $error("deep left");
  a_deep_off: assert property (dp |-> !pll_en_o && !core_clk_en_o) else $error("deep");
  a_skip_entry: assert property ($rose(deep_entry_skipped_o) |-> core_clk_en_o &&
    $past(ext_line_pending_i) && $past(core_deep_request_i)) else $error("skip");
  a_irc_select: assert property (sysclk_to_internal_8mhz_osc_o |-> core_clk_en_o &&
    internal_8mhz_osc_en_o && !$past(domain_clk_en_o)) else $error("irc");
  a_standby_off: assert property (io_hiz_o |-> !core_regulator_on_o &&
    !sram_bank1_power_o && !pll_en_o) else $error("standby");
endmodule // lpmc_ctrl_asserts
bind lpmc_ctrl lpmc_ctrl_asserts u_chk (.*);
`default_nettype wire

// *** bench/tb_low_power_mode_controller.sv ***
// Self-checking bench for the low-power mode controller.
`timescale 1ns/1ps
`default_nettype none
module tb_low_power_mode_controller;
  logic clk_i = 0, reset_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, ad, dd;
  logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, rnd = 8'h5f;
  logic [31:0] s_axi_wdata_i = 0, rd_d;
  logic [1:0] cmd = 0, resp;
  logic [11:0] ci = 0;
  wire core_deep_request_i = ci[0], event_on_pending_irq_i = ci[1], irq_pending_i = ci[2],
    wakeup_event_i = ci[3], ext_line_irq_i = ci[4], ext_line_event_i = ci[5],
    ext_line_pending_i = ci[6], rtc_alarm_i = ci[7], free_watchdog_reset_i = ci[8],
    wakeup_pin_i = ci[9], external_reset_pin_n_i = !ci[10],
    sleep_after_isr_return_i = ci[11];
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, cke,
    wait_for_interrupt_instr, wait_for_event_instr, isr, dce, osc, pll, rgo, rlp, rld, s1, s2, irc, skp, hiz, hsx, por, kp;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o, boot;
  int errors = 0, checked = 0, cyc = 0, nskip = 0, npor = 0;
  lpmc_ctrl #(.OSC_WAKE_CYCLES(2), .REG_WAKE_CYCLES(3), .POR_CYCLES(4)) u_dut (.*,
    .s_axi_wstrb_i(4'hf), .wait_for_interrupt_instr_i(wait_for_interrupt_instr), .wait_for_event_instr_i(wait_for_event_instr),
    .isr_return_lowest_i(isr), .core_clk_en_o(cke), .domain_clk_en_o(dce),
    .internal_8mhz_osc_en_o(osc), .high_speed_crystal_osc_en_o(hsx), .pll_en_o(pll),
    .core_regulator_on_o(rgo), .core_regulator_low_power_o(rlp), .io_hiz_o(hiz),
    .core_regulator_low_drive_o(rld), .sram_bank1_power_o(s1), .sram_bank2_power_o(s2),
    .sysclk_to_internal_8mhz_osc_o(irc), .deep_entry_skipped_o(skp), .por_reset_o(por),
    .boot_addr_o(boot), .wakeup_pin_keep_o(kp));
  lpmc_core_model u_core (.clk_i, .cmd_i(cmd), .wfi_o(wait_for_interrupt_instr), .wfe_o(wait_for_event_instr), .isr_o(isr));
  always #5 clk_i = !clk_i;
  function automatic logic [31:0] cw(input logic [7:0] r);
    return 32'h8000 | r[0] | (r[1] << 18) | (r[2] << 20) | (r[3] << 21);
  endfunction
  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Address and data are offered together and each is dropped once taken.
  // The response readies stay high afterwards, so back-to-back calls never toggle them twice.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {s_axi_awaddr_i, s_axi_wdata_i, s_axi_awvalid_i, s_axi_wvalid_i} <= {a, d, 2'b11};
    s_axi_bready_i <= 1;
    {ad, dd} = 2'b00;
    while (!(ad && dd)) begin
      @(posedge clk_i);
      ad |= s_axi_awready_o;
      dd |= s_axi_wready_o;
      {s_axi_awvalid_i, s_axi_wvalid_i} <= {!ad, !dd};
    end
    do @(posedge clk_i); while (!s_axi_bvalid_o);
  endtask
  task automatic rd(input logic [7:0] a);
    {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'b11};
    do @(posedge clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 0;
    do @(posedge clk_i); while (!s_axi_rvalid_o);
    {rd_d, resp} = {s_axi_rdata_o, s_axi_rresp_o};
  endtask
  // One command pulse, then the model and the controller each add one edge.
  task automatic op(input logic [1:0] c);
    cmd <= c;
    @(posedge clk_i);
    cmd <= 0;
    repeat (3) @(posedge clk_i);
  endtask
  // The cycle ceiling cuts a hang short.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    nskip <= nskip + skp;
    npor <= npor + por;
    if (cyc == 3000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 0;
    rd(8'h00);
    chk(rd_d, 32'h8000);
    rd(8'h0c);
    chk(resp, 2'b10);
    // Under sleep-on-exit the instruction is ignored and only the ISR return enters Sleep.
    ci <= 12'h800;
    op(2'h1);
    chk(cke, 1);
    op(2'h3);
    chk(cke, 0);
    ci <= 12'h004;
    repeat (2) @(posedge clk_i);
    chk(cke, 1);
    ci <= 12'h000;
    op(2'h1);
    chk({cke, dce, pll, rgo, rlp}, 5'b01110);
    ci <= 12'h00c;
    repeat (2) @(posedge clk_i);
    chk(cke, 1);
    // A wait-for-event sleep ignores a plain interrupt until an event comes.
    ci <= 12'h004;
    op(2'h2);
    chk(cke, 0);
    ci <= 12'h00c;
    repeat (2) @(posedge clk_i);
    chk(cke, 1);
    ci <= 12'h041;
    op(2'h1);
    chk(cke, 1);
    chk(nskip, 1);
    for (int i = 0; i < 4; i++) begin
      rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
      ci <= {10'h0, rnd[4], 1'b1};
      wr(8'h00, cw(rnd));
      op({i[0], !i[0]});
      chk({dce, osc, pll, rlp, rld, s1, s2}, {3'b0, rnd[0], rnd[1], ~rnd[2], ~rnd[3]});
      ci[2] <= 1;
      repeat (3) @(posedge clk_i);
      chk(dce, 0);
      ci[5:4] <= 2'b11;
      do @(posedge clk_i); while (!irc);
      chk(cke, 1);
    end
    rd(8'h00);
    chk(rd_d, cw(rnd));
    ci <= 12'h001;
    // Sources in turn: alarm, watchdog, wake pin, reset pin; the pin enable is lost at each wake.
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, 32'h8006);
      wr(8'h08, 32'h1);
      op(2'h1);
      chk({hiz, rgo, kp, hsx}, 4'b1010);
      ci[7 + k] <= 1;
      do @(posedge clk_i); while (!cke);
      ci[7 + k] <= 0;
      rd(8'h04);
      chk(rd_d, 2 + (k == 0 || k == 2));
      rd(8'h00);
      chk(rd_d, 32'h8000);
      chk(boot, 0);
    end
    chk(npor, 4 * 4);
    wr(8'h00, 32'h800c);
    rd(8'h04);
    chk(rd_d, 0);
    rd(8'h00);
    chk(rd_d, 32'h8000);
    summarize();
  end
endmodule // tb_low_power_mode_controller
`default_nettype wire
